// ---- seq_consts.svh ----
// Widths, reset values and step constants of the static memory read sequencer
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// Bus and field widths
`define ADDR_W        28
`define DATA_W        32
`define RD_WAIT_W     5
`define OE_DELAY_W    4
`define WAIT_W        6
`define LEN_W         5

// Beat length encodings
`define LEN_UNSPEC    5'h00
`define LEN_ONE       5'h01

// Zero values of the timing fields
`define RD_WAIT_ZERO  5'h00
`define WAIT_ZERO     6'h00
`define OE_ZERO       4'h0

// Address advance per beat of a known-length burst, one 32-bit word
`define ADDR_STEP     28'h0000004

// Depth of the read data buffer
`define BUF_DEPTH     2

// Reset values
`define ADDR_RESET    28'h0000000
`define LEN_RESET     5'h00

`endif

// ---- seq_pkg.sv ----
// Types shared by the static memory read sequencer
`include "seq_consts.svh"

package seq_pkg;

	typedef enum logic [2:0] {
		st_idle,
		st_proc,
		st_arb,
		st_prep1,
		st_prep2,
		st_access,
		st_wait,
		st_capture
	} seq_state_type;

	typedef struct packed {
		seq_state_type              state;
		logic [`ADDR_W-1:0]         addr;
		logic [`LEN_W-1:0]          beats_left;
		logic [`RD_WAIT_W-1:0]      rd_wait;
		logic [`OE_DELAY_W-1:0]     oe_delay;
		logic                       held;
		logic [`DATA_W-1:0]         hold;
	} seq_regs_type;

endpackage

// ---- down_counter.sv ----
// Loadable down counter that stops at zero and flags its last count
`timescale 1ns/1ns

module down_counter #(
	parameter int W = 4
) (
	input  wire logic         sys_clk_i,
	input  wire logic         nrst_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] load_val_i,
	output logic      [W-1:0] count_o,
	output logic              last_o
);

	typedef struct packed {
		logic [W-1:0] count;
	} cnt_state_type;

	cnt_state_type c;
	cnt_state_type next_c;

	always_comb begin
		next_c = c;
		if (load_i) begin
			next_c.count = load_val_i;
		end else if (c.count != {W{1'b0}}) begin
			next_c.count = c.count - {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			c <= '0;
		end else begin
			c <= next_c;
		end
	end

	assign count_o = c.count;
	assign last_o  = (c.count == {{(W-1){1'b0}}, 1'b1});

endmodule

// ---- two_entry_buffer.sv ----
// Small circular buffer with valid and ready on both sides
`timescale 1ns/1ns

module two_entry_buffer #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	input  wire logic             sys_clk_i,
	input  wire logic             nrst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W:0]   CNT_FULL = (PTR_W + 1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0]            rd_ptr;
		logic [PTR_W-1:0]            wr_ptr;
		logic [PTR_W:0]              count;
	} buf_state_type;

	buf_state_type b;
	buf_state_type next_b;
	logic          push;
	logic          pop;

	always_comb begin
		next_b = b;
		push   = in_valid_i && (b.count != CNT_FULL);
		pop    = out_ready_i && (b.count != '0);
		if (push) begin
			next_b.mem[b.wr_ptr] = in_data_i;
			next_b.wr_ptr = (b.wr_ptr == PTR_LAST) ? '0 : b.wr_ptr + PTR_W'(1);
		end
		if (pop) begin
			next_b.rd_ptr = (b.rd_ptr == PTR_LAST) ? '0 : b.rd_ptr + PTR_W'(1);
		end
		if (push && !pop) begin
			next_b.count = b.count + {{PTR_W{1'b0}}, 1'b1};
		end else if (pop && !push) begin
			next_b.count = b.count - {{PTR_W{1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			b <= '0;
		end else begin
			b <= next_b;
		end
	end

	// Full refuses a push even when a pop lands in the same cycle; simpler timing
	assign in_ready_o  = (b.count != CNT_FULL);
	assign out_valid_o = (b.count != '0);
	assign out_data_o  = b.mem[b.rd_ptr];

endmodule

// ---- static_memory_read_sequencer.sv ----
// Read-path timing sequencer for external static memory banks
`timescale 1ns/1ns
`include "seq_consts.svh"

module static_memory_read_sequencer
	import seq_pkg::*;
(
	input  wire logic                   sys_clk_i,
	input  wire logic                   nrst_i,
	input  wire logic                   req_valid_i,
	output logic                        req_ready_o,
	input  wire logic [`ADDR_W-1:0]     req_addr_i,
	input  wire logic [`LEN_W-1:0]      req_len_i,
	input  wire logic [`RD_WAIT_W-1:0]  read_wait_count_i,
	input  wire logic [`OE_DELAY_W-1:0] oe_delay_count_i,
	output logic                        rd_valid_o,
	input  wire logic                   rd_ready_i,
	output logic      [`DATA_W-1:0]     rd_data_o,
	output logic      [`ADDR_W-1:0]     mem_addr_o,
	output logic                        mem_cs_n_o,
	output logic                        mem_oe_n_o,
	input  wire logic [`DATA_W-1:0]     mem_data_i
);

	////////////////////////////////////////////////////////////////////////////////
	// State and helpers

	seq_regs_type            s;
	seq_regs_type            next_s;
	logic                    more_beats;
	logic [`WAIT_W-1:0]      first_wait;
	logic                    wait_load;
	logic [`WAIT_W-1:0]      wait_load_val;
	logic                    wait_last;
	logic                    oe_load;
	logic [`OE_DELAY_W-1:0]  oe_count;
	logic                    buf_in_valid;
	logic                    buf_in_ready;
	logic                    mem_active;
	logic [`DATA_W-1:0]      buf_in_data;
	logic                    capture_stall;

	assign more_beats = (s.beats_left > `LEN_ONE);
	// Both delays lengthen the first access; later burst beats pay the read wait only
	assign first_wait = {1'b0, s.rd_wait} + {2'b00, s.oe_delay};
	assign capture_stall = (s.state == st_capture) && !buf_in_ready;
	// Once the address has moved on, a stalled capture must reuse the word it first saw
	assign buf_in_data = s.held ? s.hold : mem_data_i;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		next_s        = s;
		wait_load     = 1'b0;
		wait_load_val = `WAIT_ZERO;
		oe_load       = 1'b0;
		buf_in_valid  = 1'b0;
		case (s.state)
			st_idle: begin
				if (req_valid_i) begin
					next_s.state    = st_proc;
					next_s.addr     = req_addr_i;
					next_s.rd_wait  = read_wait_count_i;
					next_s.oe_delay = oe_delay_count_i;
					// Unspecified length runs as a lone read; the host asks again per beat
					next_s.beats_left = (req_len_i == `LEN_UNSPEC) ? `LEN_ONE : req_len_i;
				end
			end
			st_proc: begin
				next_s.state = st_arb;
			end
			st_arb: begin
				next_s.state = st_prep1;
			end
			st_prep1: begin
				next_s.state = st_prep2;
			end
			st_prep2: begin
				oe_load      = 1'b1;
				next_s.state = st_access;
			end
			st_access: begin
				wait_load     = 1'b1;
				wait_load_val = first_wait;
				next_s.state  = (first_wait == `WAIT_ZERO) ? st_capture : st_wait;
			end
			st_wait: begin
				if (wait_last) begin
					next_s.state = st_capture;
				end
			end
			st_capture: begin
				buf_in_valid = 1'b1;
				if (buf_in_ready) begin
					next_s.held = 1'b0;
					if (more_beats) begin
						next_s.beats_left = s.beats_left - `LEN_ONE;
						wait_load         = 1'b1;
						wait_load_val     = {1'b0, s.rd_wait};
						next_s.state      = (s.rd_wait == `RD_WAIT_ZERO) ? st_capture : st_wait;
					end else begin
						next_s.state = st_idle;
					end
				end else begin
					// A full buffer holds the access open; the next address is already out
					next_s.held = 1'b1;
					next_s.hold = buf_in_data;
				end
			end
			default: begin
				next_s.state = st_idle;
			end
		endcase
		// Next beat's address goes out while the current word returns
		if ((next_s.state == st_capture) && (next_s.beats_left > `LEN_ONE) && !capture_stall) begin
			next_s.addr = s.addr + `ADDR_STEP;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '{state: st_idle, addr: `ADDR_RESET, beats_left: `LEN_RESET, default: '0};
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counters and buffer

	down_counter #(
		.W (`WAIT_W)
	) u_wait_counter (
		.sys_clk_i  (sys_clk_i),
		.nrst_i     (nrst_i),
		.load_i     (wait_load),
		.load_val_i (wait_load_val),
		.count_o    (),
		.last_o     (wait_last)
	);

	down_counter #(
		.W (`OE_DELAY_W)
	) u_oe_counter (
		.sys_clk_i  (sys_clk_i),
		.nrst_i     (nrst_i),
		.load_i     (oe_load),
		.load_val_i (s.oe_delay),
		.count_o    (oe_count),
		.last_o     ()
	);

	two_entry_buffer #(
		.WIDTH (`DATA_W),
		.DEPTH (`BUF_DEPTH)
	) u_read_buffer (
		.sys_clk_i   (sys_clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (buf_in_valid),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (buf_in_data),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pins

	// Selects decode from state flops; one decode level of the 3-bit binary-encoded state, not one-hot
	assign mem_active  = (s.state == st_access) || (s.state == st_wait) || (s.state == st_capture);
	assign mem_cs_n_o  = !mem_active;
	assign mem_oe_n_o  = !mem_active || (oe_count != `OE_ZERO);
	assign mem_addr_o  = s.addr;
	assign req_ready_o = (s.state == st_idle);

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_front_latency;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(req_valid_i && req_ready_o) |=> mem_cs_n_o [*4] ##1 !mem_cs_n_o;
	endproperty
	a_front_latency: assert property (p_front_latency)
		else $error("chip select not asserted five cycles after request");

	property p_addr_with_select;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		$fell(mem_cs_n_o) |-> $stable(mem_addr_o) && (mem_oe_n_o == (s.oe_delay != `OE_ZERO));
	endproperty
	a_addr_with_select: assert property (p_addr_with_select)
		else $error("address or enable not presented with chip select");

	property p_two_read_waits;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		($fell(mem_cs_n_o) && s.rd_wait == 5'h02 && s.oe_delay == 4'h0 && !rd_valid_o)
		|-> !rd_valid_o [*4] ##1 rd_valid_o;
	endproperty
	a_two_read_waits: assert property (p_two_read_waits)
		else $error("two wait read did not deliver four cycles after select");

	property p_oe_delay_two;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		($fell(mem_cs_n_o) && s.oe_delay == 4'h2) |-> mem_oe_n_o [*2] ##1 !mem_oe_n_o;
	endproperty
	a_oe_delay_two: assert property (p_oe_delay_two)
		else $error("output enable not asserted in third cycle of access");

	property p_oe_delay_response;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		($fell(mem_cs_n_o) && s.oe_delay == 4'h2 && s.rd_wait == 5'h00 && !rd_valid_o)
		|-> !rd_valid_o [*4] ##1 rd_valid_o;
	endproperty
	a_oe_delay_response: assert property (p_oe_delay_response)
		else $error("output enable delay did not lengthen response by two");

	property p_single_returns_idle;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(mem_cs_n_o) |-> req_ready_o;
	endproperty
	a_single_returns_idle: assert property (p_single_returns_idle)
		else $error("sequencer not idle after chip select release");

	property p_burst_holds_select;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(s.state == st_capture && buf_in_ready && more_beats) |=> !mem_cs_n_o;
	endproperty
	a_burst_holds_select: assert property (p_burst_holds_select)
		else $error("chip select dropped inside known length burst");

	property p_zero_wait_pipeline;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(s.state == st_capture && buf_in_ready && more_beats && s.rd_wait == 5'h00)
		|=> s.state == st_capture && rd_valid_o;
	endproperty
	a_zero_wait_pipeline: assert property (p_zero_wait_pipeline)
		else $error("zero wait burst beat not captured back to back");

	property p_addr_issue;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(s.state == st_capture && s.beats_left > `LEN_ONE && !$past(capture_stall))
		|-> mem_addr_o == $past(mem_addr_o) + `ADDR_STEP;
	endproperty
	a_addr_issue: assert property (p_addr_issue)
		else $error("next burst address not issued while capturing");

	property p_deliver_after_capture;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(s.state == st_capture && buf_in_ready && !rd_valid_o) |=> rd_valid_o;
	endproperty
	a_deliver_after_capture: assert property (p_deliver_after_capture)
		else $error("captured word not delivered one cycle later");

	property p_burst_two_waits;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(s.state == st_capture && buf_in_ready && more_beats && s.rd_wait == 5'h02)
		|=> (s.state == st_wait) [*2] ##1 s.state == st_capture;
	endproperty
	a_burst_two_waits: assert property (p_burst_two_waits)
		else $error("burst beat did not take two wait cycles");

	property p_zero_wait_capture;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		($fell(mem_cs_n_o) && s.rd_wait == 5'h00 && s.oe_delay == 4'h0) |=> s.state == st_capture;
	endproperty
	a_zero_wait_capture: assert property (p_zero_wait_capture)
		else $error("zero wait read not captured in cycle after address");

	property p_oe_release_with_cs;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(mem_cs_n_o) |-> $rose(mem_oe_n_o);
	endproperty
	a_oe_release_with_cs: assert property (p_oe_release_with_cs)
		else $error("output enable not released with chip select");

	property p_oe_max_delay;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		($fell(mem_cs_n_o) && s.oe_delay == 4'hf) |-> ##[15:15] !mem_oe_n_o && $past(mem_oe_n_o);
	endproperty
	a_oe_max_delay: assert property (p_oe_max_delay)
		else $error("fifteen cycle output enable delay not honoured");

	property p_reset_idle;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(nrst_i) |-> req_ready_o && mem_cs_n_o && mem_oe_n_o;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("sequencer not idle after reset");

	property p_idle_released;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(s.state == st_idle) |-> mem_cs_n_o && mem_oe_n_o;
	endproperty
	a_idle_released: assert property (p_idle_released)
		else $error("memory selects active while idle");

endmodule

// ---- sram_model.sv ----
// Behavioural external static memory answering reads while selected and enabled
`timescale 1ns/1ns
`include "seq_consts.svh"

module sram_model (
	input  wire logic               sys_clk_i,
	input  wire logic [`ADDR_W-1:0] mem_addr_i,
	input  wire logic               mem_cs_n_i,
	input  wire logic               mem_oe_n_i,
	output logic      [`DATA_W-1:0] mem_data_o
);
	logic [`DATA_W-1:0] last = 32'h00000000;
	logic [`ADDR_W-1:0] addr_seen = 28'h0000000;
	logic               drive;

	assign drive = !mem_cs_n_i && !mem_oe_n_i;
	// One-cycle access: the word returned belongs to the address of the previous cycle
	// Released bus shows the inverse of the last word, so a late capture never matches
	assign mem_data_o = drive ? {~addr_seen[3:0], addr_seen} : ~last;

	always @(posedge sys_clk_i) begin
		addr_seen <= mem_addr_i;
		if (drive) begin
			last <= mem_data_o;
		end
	end
endmodule

// ---- tb_top.sv ----
// Self-checking testbench of the static memory read sequencer
`timescale 1ns/1ns
`include "seq_consts.svh"

module tb_top;
	logic                   sys_clk;
	logic                   nrst;
	logic                   req_valid;
	logic                   req_ready;
	logic [`ADDR_W-1:0]     req_addr;
	logic [`LEN_W-1:0]      req_len;
	logic [`RD_WAIT_W-1:0]  rd_wait;
	logic [`OE_DELAY_W-1:0] oe_delay;
	logic                   rd_valid;
	logic                   rd_ready;
	logic [`DATA_W-1:0]     rd_data;
	logic [`ADDR_W-1:0]     mem_addr;
	logic                   cs_n;
	logic                   oe_n;
	logic [`DATA_W-1:0]     mem_data;
	int                     fails;
	int                     check_count;
	int                     cycles = 0;
	int                     cs_fall;
	int                     oe_fall;
	int                     cs_rise;
	int                     oe_rise;
	int                     nw;
	int                     vcyc[8];
	logic [`DATA_W-1:0]     vdat[8];
	logic [`ADDR_W-1:0]     addr_at[64];

	static_memory_read_sequencer static_memory_read_sequencer_i (
		.sys_clk_i(sys_clk), .nrst_i(nrst), .req_valid_i(req_valid), .req_ready_o(req_ready),
		.req_addr_i(req_addr), .req_len_i(req_len), .read_wait_count_i(rd_wait),
		.oe_delay_count_i(oe_delay), .rd_valid_o(rd_valid), .rd_ready_i(rd_ready),
		.rd_data_o(rd_data), .mem_addr_o(mem_addr), .mem_cs_n_o(cs_n), .mem_oe_n_o(oe_n),
		.mem_data_i(mem_data)
	);

	sram_model sram_model_i (
		.sys_clk_i(sys_clk), .mem_addr_i(mem_addr), .mem_cs_n_i(cs_n), .mem_oe_n_i(oe_n),
		.mem_data_o(mem_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (fails == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cmp_cyc(input int got, input int exp, input string what);
		check_count++;
		if (got != exp) begin
			fails++;
			$display("unexpected at %0t: %s is %0d, wanted %0d", $time, what, got, exp);
		end
	endtask

	task automatic cmp_word(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s is %h, wanted %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [`DATA_W-1:0] exp_word(input logic [`ADDR_W-1:0] a);
		return {~a[3:0], a};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Cycle k is the state after the k-th edge, counting the taking edge as the first
	task automatic run_op(input logic [`ADDR_W-1:0] a, input logic [`LEN_W-1:0] len,
			input logic [`RD_WAIT_W-1:0] rd, input logic [`OE_DELAY_W-1:0] oe, input int n, input int stall);
		int k;
		int guard;
		@(negedge sys_clk);
		cs_fall = -1;
		oe_fall = -1;
		cs_rise = -1;
		oe_rise = -1;
		nw = 0;
		guard = 0;
		req_valid = 1'b1;
		req_addr = a;
		req_len = len;
		rd_wait = rd;
		oe_delay = oe;
		rd_ready = (stall == 0);
		while (req_ready !== 1'b1 && guard < 50) begin
			@(negedge sys_clk);
			guard++;
		end
		for (k = 1; k < 64; k++) begin
			@(negedge sys_clk);
			req_valid = 1'b0;
			addr_at[k] = mem_addr;
			if (cs_fall < 0 && cs_n === 1'b0) cs_fall = k;
			if (oe_fall < 0 && oe_n === 1'b0) oe_fall = k;
			if (cs_fall > 0 && cs_rise < 0 && cs_n === 1'b1) cs_rise = k;
			if (oe_fall > 0 && oe_rise < 0 && oe_n === 1'b1) oe_rise = k;
			rd_ready = (k >= stall);
			if (rd_valid === 1'b1 && rd_ready === 1'b1 && nw < 8) begin
				vcyc[nw] = k;
				vdat[nw] = rd_data;
				nw++;
			end
			if (nw == n && cs_rise > 0) break;
		end
	endtask

	task automatic check_single(input logic [`ADDR_W-1:0] a, input int rd, input int oe);
		cmp_cyc(nw, 1, "word count");
		cmp_cyc(cs_fall, 5, "select cycle");
		cmp_word({4'h0, addr_at[5]}, {4'h0, a}, "address with select");
		cmp_cyc(oe_fall, 5 + oe, "enable cycle");
		cmp_cyc(vcyc[0], 7 + rd + oe, "word cycle");
		cmp_cyc(cs_rise, 7 + rd + oe, "select release");
		cmp_cyc(oe_rise, cs_rise, "enable release");
		cmp_word(vdat[0], exp_word(a), "word");
	endtask

	task automatic check_burst(input logic [`ADDR_W-1:0] a, input int n, input int rd);
		int i;
		cmp_cyc(nw, n, "burst word count");
		for (i = 0; i < n; i++) begin
			cmp_cyc(vcyc[i], 7 + rd + i * (rd + 1), "beat cycle");
			cmp_word(vdat[i], exp_word(a + 28'(4 * i)), "beat word");
			cmp_word({4'h0, addr_at[5 + i * (rd + 1)]}, {4'h0, a + 28'(4 * i)}, "beat address");
		end
		cmp_cyc(cs_rise, 7 + rd + (n - 1) * (rd + 1), "burst select release");
		cmp_cyc(oe_rise, cs_rise, "burst enable release");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		cmp_word({31'h0, req_ready}, 32'h00000001, "ready after reset");
		cmp_word({31'h0, cs_n}, 32'h00000001, "select after reset");
		cmp_word({31'h0, oe_n}, 32'h00000001, "enable after reset");
		cmp_word({31'h0, rd_valid}, 32'h00000000, "valid after reset");
	endtask

	task automatic t_plain();
		run_op(28'h0000100, `LEN_UNSPEC, 5'h00, 4'h0, 1, 0);
		check_single(28'h0000100, 0, 0);
	endtask

	task automatic t_waits();
		run_op(28'h0000204, `LEN_UNSPEC, 5'h02, 4'h0, 1, 0);
		check_single(28'h0000204, 2, 0);
		run_op(28'h0000308, `LEN_UNSPEC, 5'h00, 4'h2, 1, 0);
		check_single(28'h0000308, 0, 2);
		run_op(28'h000040c, `LEN_UNSPEC, 5'h00, 4'hf, 1, 0);
		check_single(28'h000040c, 0, 15);
	endtask

	task automatic t_independent();
		run_op(28'h0000500, `LEN_UNSPEC, 5'h00, 4'h0, 1, 0);
		check_single(28'h0000500, 0, 0);
		run_op(28'h0000504, `LEN_ONE, 5'h00, 4'h0, 1, 0);
		check_single(28'h0000504, 0, 0);
	endtask

	task automatic t_bursts();
		run_op(28'h0000600, 5'h04, 5'h00, 4'h0, 4, 0);
		check_burst(28'h0000600, 4, 0);
		run_op(28'h0000700, 5'h04, 5'h02, 4'h0, 4, 0);
		check_burst(28'h0000700, 4, 2);
	endtask

	// Consumer stalls past the buffer depth; no word may be lost or reordered
	task automatic t_stall();
		int i;
		run_op(28'h0000800, 5'h04, 5'h00, 4'h0, 4, 20);
		cmp_cyc(nw, 4, "words after stall");
		cmp_cyc(vcyc[0], 20, "first word after stall");
		cmp_cyc(int'(cs_rise > 20), 1, "select held through stall");
		cmp_cyc(oe_rise, cs_rise, "enable release after stall");
		for (i = 0; i < 4; i++) begin
			cmp_word(vdat[i], exp_word(28'h0000800 + 28'(4 * i)), "stalled word");
		end
	endtask

	initial begin
		nrst = 1'b0;
		req_valid = 1'b0;
		req_addr = 28'h0000000;
		req_len = 5'h00;
		rd_wait = 5'h00;
		oe_delay = 4'h0;
		rd_ready = 1'b0;
		fails = 0;
		check_count = 0;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		nrst = 1'b1;
		t_reset();
		t_plain();
		t_waits();
		t_independent();
		t_bursts();
		t_stall();
		tally_and_finish();
	end
endmodule
